// ===== src/wake_meas_pkg.sv
// shared constants and types of the wake input measurement block
package wake_meas_pkg;

  // ---------------------------------------------------------------------------
  // clock and filter timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS        = 20;
  localparam int unsigned FILTER_TIME_SHORT_US = 16;
  localparam int unsigned FILTER_TIME_LONG_US  = 64;
  localparam int unsigned FILT_CNT_W           = 12;
  // least times round up to whole cycles
  localparam logic [FILT_CNT_W-1:0] FILTER_SHORT_CYC =
    FILT_CNT_W'((FILTER_TIME_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [FILT_CNT_W-1:0] FILTER_LONG_CYC =
    FILT_CNT_W'((FILTER_TIME_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------------------
  // register port and map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NUM_PINS = 3;
  localparam logic [ADDR_W-1:0] ADDR_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PULL       = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_FILTER     = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_EN    = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_STAT  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = 8'h1c;

  // field positions and reset values
  localparam int unsigned CTRL_MEAS_BIT   = 0;
  localparam int unsigned EVT_FAULT_BIT   = 3;
  localparam logic [2:0]  MEAS_PIN_MASK   = 3'h3;
  localparam logic        MEAS_RST        = 1'b0;
  localparam logic [5:0]  PULL_RST        = 6'h00;
  localparam logic [5:0]  FILTER_RST      = 6'h00;
  localparam logic [2:0]  WAKE_EN_RST     = 3'h0;
  localparam logic [3:0]  EVENT_MASK_RST  = 4'h0;

  // pull configuration codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;

  // filter configuration codes
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG  = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_T1    = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_T2    = 2'h3;

  // operating mode from the device-mode controller
  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } op_mode_t;

endpackage

// ===== src/wake_filter.sv
// glitch filter for one wake comparator input
`timescale 1ns/1ns
`default_nettype none
module wake_filter (
  input  wire logic                              mclk,      // system clock
  input  wire logic                              resetn,    // sync reset, low
  input  wire logic                              level_in,  // comparator level
  input  wire logic                              sample_en, // sensing active
  input  wire logic [wake_meas_pkg::FILT_CNT_W-1:0] limit,  // filter cycles
  output logic                                   level_o,   // accepted level
  output logic                                   edge_o     // accepted change
);
  import wake_meas_pkg::*;

  typedef struct packed {
    logic                  lvl;
    logic [FILT_CNT_W-1:0] cnt;
    logic                  edg;
  } filt_state_t;

  filt_state_t s_q;
  filt_state_t s_d;

  // ---------------------------------------------------------------------------
  // restart interval on each crossing, accept only after a steady interval
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.edg = 1'b0;
    if (!sample_en || level_in == s_q.lvl) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == limit - FILT_CNT_W'(1)) begin
      s_d.lvl = level_in;
      s_d.cnt = '0;
      s_d.edg = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + FILT_CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.lvl;
  assign edge_o  = s_q.edg;

  a_edge_after_hold : assert property (@(posedge mclk) disable iff (!resetn)
    s_d.edg |-> (s_q.cnt == limit - FILT_CNT_W'(1)) && sample_en && level_in != s_q.lvl)
    else $error("filter accepted a change before the interval ran out");

endmodule
`default_nettype wire

// ===== src/wake_pull.sv
// pull current source selection for one wake pin
`timescale 1ns/1ns
`default_nettype none
module wake_pull (
  input  wire logic [1:0] pull_cfg,  // pull configuration field
  input  wire logic       level,     // accepted pin level
  input  wire logic       force_off, // measurement override
  output logic            pull_up,   // pull-up source on
  output logic            pull_down  // pull-down source on
);
  import wake_meas_pkg::*;

  // decode pull field, auto follows the level, override wins
  always_comb begin
    pull_up   = 1'b0;
    pull_down = 1'b0;
    if (!force_off) begin
      case (pull_cfg)
        PULL_DOWN: pull_down = 1'b1;
        PULL_UP:   pull_up   = 1'b1;
        PULL_AUTO: begin
          pull_up   = level;
          pull_down = ~level;
        end
        default: pull_up = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== src/wake_measure_ctrl.sv
// wake inputs with the alternate voltage measurement mode
//
// Behaviour
// - reset: measurement off, switch open
// - enable and normal mode close switch
// - any other mode keeps switch open
// - measurement forces pins one, two pulls off
// - measurement blocks pin one, two events
// - settings stay writable but are ignored
// - no status updates for gated pins
// - refused sleep sets fault, requests restart
// - no measurement: enabled pins may wake
// - short filter about 16 us
// - long filter about 64 us
// - filter restarts on each crossing
// - two-bit field selects filter and sensing
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module wake_measure_ctrl (
  input  wire logic                            mclk,         // 50 MHz clock
  input  wire logic                            resetn,       // sync reset, low
  input  wire logic [wake_meas_pkg::ADDR_W-1:0] addr,        // register address
  input  wire logic [wake_meas_pkg::DATA_W-1:0] wdata,       // write data
  input  wire logic                            wr,           // write strobe
  input  wire logic                            rd,           // read strobe
  output logic      [wake_meas_pkg::DATA_W-1:0] rdata,       // read data, next cycle
  input  wire wake_meas_pkg::op_mode_t         op_mode,      // current device mode
  input  wire logic                            sleep_cmd,    // sleep request pulse
  input  wire logic [2:0]                      wake_in,      // comparator levels
  input  wire logic                            timer_one_on, // cyclic timer 1 on-time
  input  wire logic                            timer_two_on, // cyclic timer 2 on-time
  output logic                                 measure_pass_switch, // pin one to two
  output logic      [2:0]                      pull_up,      // pull-up sources
  output logic      [2:0]                      pull_down,    // pull-down sources
  output logic                                 wake_req,     // wake-up pulse
  output logic                                 sleep_go,     // sleep accepted pulse
  output logic                                 restart_req,  // restart pulse
  output logic                                 irq           // level interrupt
);
  import wake_meas_pkg::*;

  typedef struct packed {
    logic              meas;
    logic [5:0]        pull;
    logic [5:0]        flt;
    logic [2:0]        wen;
    logic [2:0]        wstat;
    logic [2:0]        lvl;
    logic [3:0]        evt;
    logic [3:0]        mask;
    logic [DATA_W-1:0] rdata;
    logic              wake;
    logic              sleep;
    logic              restart;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic [2:0] gate;
  logic [2:0] flt_level;
  logic [2:0] flt_edge;
  logic [2:0] edge_vis;
  logic [2:0] sample_en;
  logic [FILT_CNT_W-1:0] limit [NUM_PINS];

  // ---------------------------------------------------------------------------
  // filter field decoding
  // ---------------------------------------------------------------------------

  // only static long uses the long interval, all others use the short one
  function automatic logic [FILT_CNT_W-1:0] filter_limit(input logic [1:0] cfg);
    if (cfg == FLT_STATIC_LONG) begin
      filter_limit = FILTER_LONG_CYC;
    end else begin
      filter_limit = FILTER_SHORT_CYC;
    end
  endfunction

  // static sensing always samples, cyclic only during its timer on-time
  function automatic logic filter_sample(input logic [1:0] cfg, input logic t1,
                                         input logic t2);
    case (cfg)
      FLT_CYCLIC_T1: filter_sample = t1;
      FLT_CYCLIC_T2: filter_sample = t2;
      default:       filter_sample = 1'b1;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // per pin filter and pull sources
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      // measurement touches pins one and two only
      assign gate[gi]      = s_q.meas & MEAS_PIN_MASK[gi];
      assign limit[gi]     = filter_limit(s_q.flt[2*gi +: 2]);
      assign sample_en[gi] = filter_sample(s_q.flt[2*gi +: 2], timer_one_on,
                                           timer_two_on) & ~gate[gi];
      // gated pins produce no events
      assign edge_vis[gi]  = flt_edge[gi] & ~gate[gi];

      wake_filter u_filter (
        .mclk      (mclk),
        .resetn    (resetn),
        .level_in  (wake_in[gi]),
        .sample_en (sample_en[gi]),
        .limit     (limit[gi]),
        .level_o   (flt_level[gi]),
        .edge_o    (flt_edge[gi])
      );

      wake_pull u_pull (
        .pull_cfg  (s_q.pull[2*gi +: 2]),
        .level     (flt_level[gi]),
        .force_off (gate[gi]),
        .pull_up   (pull_up[gi]),
        .pull_down (pull_down[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // registers, status and mode checks
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.rdata   = '0;
    s_d.wake    = 1'b0;
    s_d.sleep   = 1'b0;
    s_d.restart = 1'b0;

    // software writes; pin settings always accepted
    if (wr) begin
      case (addr)
        ADDR_CTRL:       s_d.meas = wdata[CTRL_MEAS_BIT];
        ADDR_PULL:       s_d.pull = wdata[5:0];
        ADDR_FILTER:     s_d.flt  = wdata[5:0];
        ADDR_WAKE_EN:    s_d.wen  = wdata[2:0];
        ADDR_WAKE_STAT:  s_d.wstat = s_q.wstat & ~wdata[2:0];
        ADDR_EVENT_STAT: s_d.evt  = s_q.evt & ~wdata[3:0];
        ADDR_EVENT_MASK: s_d.mask = wdata[3:0];
        default:         s_d.mask = s_d.mask;
      endcase
    end

    // read mux, unmapped reads as zero
    if (rd) begin
      case (addr)
        ADDR_CTRL:       s_d.rdata = DATA_W'(s_q.meas);
        ADDR_PULL:       s_d.rdata = DATA_W'(s_q.pull);
        ADDR_FILTER:     s_d.rdata = DATA_W'(s_q.flt);
        ADDR_WAKE_EN:    s_d.rdata = DATA_W'(s_q.wen);
        ADDR_WAKE_STAT:  s_d.rdata = DATA_W'(s_q.wstat);
        ADDR_LEVEL_STAT: s_d.rdata = DATA_W'(s_q.lvl);
        ADDR_EVENT_STAT: s_d.rdata = DATA_W'(s_q.evt);
        ADDR_EVENT_MASK: s_d.rdata = DATA_W'(s_q.mask);
        default:         s_d.rdata = '0;
      endcase
    end

    // hardware sets after the clear so a coincident event wins
    for (int i = 0; i < NUM_PINS; i++) begin
      if (edge_vis[i] && s_q.wen[i]) begin
        s_d.wstat[i] = 1'b1;
        s_d.evt[i]   = 1'b1;
      end
    end

    // mode dependent level tracking and wake-up
    case (op_mode)
      MODE_NORMAL, MODE_STOP: begin
        for (int i = 0; i < NUM_PINS; i++) begin
          if (!gate[i]) begin
            s_d.lvl[i] = flt_level[i];
          end
        end
      end
      MODE_SLEEP, MODE_FAILSAFE: begin
        s_d.wake = |(edge_vis & s_q.wen);
      end
      default: s_d.wake = 1'b0;
    endcase

    // sleep with only the gated pins as wake sources is refused
    if (sleep_cmd) begin
      if (s_q.meas && |(s_q.wen & MEAS_PIN_MASK) && !(|(s_q.wen & ~MEAS_PIN_MASK))) begin
        s_d.evt[EVT_FAULT_BIT] = 1'b1;
        s_d.restart            = 1'b1;
      end else begin
        s_d.sleep = 1'b1;
      end
    end
  end

  // state register, everything off out of reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q      <= '0;
      s_q.meas <= MEAS_RST;
      s_q.pull <= PULL_RST;
      s_q.flt  <= FILTER_RST;
      s_q.wen  <= WAKE_EN_RST;
      s_q.mask <= EVENT_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------

  // switch follows the mode input directly, no register delay
  assign measure_pass_switch = s_q.meas && (op_mode == MODE_NORMAL);
  assign rdata       = s_q.rdata;
  assign wake_req    = s_q.wake;
  assign sleep_go    = s_q.sleep;
  assign restart_req = s_q.restart;
  assign irq         = |(s_q.evt & s_q.mask);

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_reset_meas_off : assert property (@(posedge mclk)
    !resetn |=> !s_q.meas && !measure_pass_switch)
    else $error("measurement not off after reset");

  a_switch_closes : assert property (@(posedge mclk) disable iff (!resetn)
    (wr && addr == ADDR_CTRL && wdata[CTRL_MEAS_BIT]) ##1 (op_mode == MODE_NORMAL)
      |-> measure_pass_switch)
    else $error("switch open in normal mode with measurement on");

  a_switch_other_mode : assert property (@(posedge mclk) disable iff (!resetn)
    (op_mode != MODE_NORMAL) |-> !measure_pass_switch)
    else $error("switch closed outside normal mode");

  a_switch_follows : assert property (@(posedge mclk) disable iff (!resetn)
    (measure_pass_switch ##1 op_mode != MODE_NORMAL) |-> !measure_pass_switch)
    else $error("switch late to open on leaving normal mode");

  a_pulls_forced_off : assert property (@(posedge mclk) disable iff (!resetn)
    s_q.meas |-> (pull_up[1:0] == 2'h0) && (pull_down[1:0] == 2'h0))
    else $error("pull source active during measurement");

  a_status_frozen : assert property (@(posedge mclk) disable iff (!resetn)
    (s_q.meas && !(wr && addr == ADDR_CTRL)) |=>
      (s_q.lvl[1:0] == $past(s_q.lvl[1:0])) &&
      ((s_q.wstat[1:0] & ~$past(s_q.wstat[1:0])) == 2'h0))
    else $error("gated pin status updated during measurement");

  a_sleep_refused : assert property (@(posedge mclk) disable iff (!resetn)
    (sleep_cmd && s_q.meas && s_q.wen[2:0] inside {3'h1, 3'h2, 3'h3}) |=>
      restart_req && !sleep_go && s_q.evt[EVT_FAULT_BIT])
    else $error("refused sleep not flagged");

  a_wake_allowed : assert property (@(posedge mclk) disable iff (!resetn)
    (op_mode == MODE_SLEEP && flt_edge[0] && s_q.wen[0] && !s_q.meas) |=> wake_req)
    else $error("enabled pin one did not wake");

  a_pin3_unaffected : assert property (@(posedge mclk) disable iff (!resetn)
    (op_mode inside {MODE_SLEEP, MODE_FAILSAFE} && flt_edge[2] && s_q.wen[2]) |=> wake_req)
    else $error("third pin wake lost");

  a_filter_select : assert property (@(posedge mclk) disable iff (!resetn)
    (s_q.flt[1:0] == FLT_STATIC_LONG) |-> (limit[0] == FILTER_LONG_CYC))
    else $error("long filter not selected");

  // ---------------------------------------------------------------------------
  // further rule checks
  // ---------------------------------------------------------------------------
  a_switch_needs_meas : assert property (@(posedge mclk) disable iff (!resetn)
    !s_q.meas |-> !measure_pass_switch)
    else $error("switch closed with measurement off");

  a_gated_no_wake : assert property (@(posedge mclk) disable iff (!resetn)
    (s_q.meas && !flt_edge[2]) |=> !wake_req)
    else $error("gated pin produced a wake");

  // settings still land while gated
  a_pull_written : assert property (@(posedge mclk) disable iff (!resetn)
    (wr && addr == ADDR_PULL) |=> (s_q.pull == $past(wdata[5:0])))
    else $error("pull setting write lost");

  a_filter_written : assert property (@(posedge mclk) disable iff (!resetn)
    (wr && addr == ADDR_FILTER) |=> (s_q.flt == $past(wdata[5:0])))
    else $error("filter setting write lost");

  a_enable_written : assert property (@(posedge mclk) disable iff (!resetn)
    (wr && addr == ADDR_WAKE_EN) |=> (s_q.wen == $past(wdata[2:0])))
    else $error("wake enable write lost");

  a_level_tracks : assert property (@(posedge mclk) disable iff (!resetn)
    (op_mode == MODE_NORMAL && !s_q.meas) |=> (s_q.lvl[1:0] == $past(flt_level[1:0])))
    else $error("level status not tracking with measurement off");

  a_sleep_accepted : assert property (@(posedge mclk) disable iff (!resetn)
    (sleep_cmd && !s_q.meas) |=> (sleep_go && !restart_req))
    else $error("sleep refused with measurement off");

  a_fault_sticky : assert property (@(posedge mclk) disable iff (!resetn)
    (s_q.evt[EVT_FAULT_BIT] && !(wr && addr == ADDR_EVENT_STAT)) |=> s_q.evt[EVT_FAULT_BIT])
    else $error("fault flag lost without a clear");

  // wake pulses only from enabled edges in the low-power modes
  a_wake_only_low_power : assert property (@(posedge mclk) disable iff (!resetn)
    !(op_mode inside {MODE_SLEEP, MODE_FAILSAFE}) |=> !wake_req)
    else $error("wake pulse outside sleep or failsafe");

  a_wake_needs_enable : assert property (@(posedge mclk) disable iff (!resetn)
    !(|(flt_edge & s_q.wen)) |=> !wake_req)
    else $error("wake pulse without an enabled edge");

  a_short_select : assert property (@(posedge mclk) disable iff (!resetn)
    (s_q.flt[1:0] != FLT_STATIC_LONG) |-> (limit[0] == FILTER_SHORT_CYC))
    else $error("short filter not selected");

  // third pin keeps its own behaviour
  a_pin3_pull_kept : assert property (@(posedge mclk) disable iff (!resetn)
    (s_q.pull[5:4] == PULL_DOWN) |-> (pull_down[2] && !pull_up[2]))
    else $error("third pin pull setting not applied");

  a_pin3_level : assert property (@(posedge mclk) disable iff (!resetn)
    (op_mode == MODE_NORMAL) |=> (s_q.lvl[2] == $past(flt_level[2])))
    else $error("third pin level status not tracking");

  c_level_frozen : cover property (@(posedge mclk) disable iff (!resetn)
    s_q.meas && op_mode == MODE_NORMAL && flt_level[0] != wake_in[0]);

  c_switch_closed : cover property (@(posedge mclk) disable iff (!resetn)
    measure_pass_switch);
  c_sleep_refused : cover property (@(posedge mclk) disable iff (!resetn)
    restart_req);
  c_wake_up : cover property (@(posedge mclk) disable iff (!resetn)
    wake_req);
  c_irq_raised : cover property (@(posedge mclk) disable iff (!resetn)
    irq);

endmodule
`default_nettype wire

// ===== tb/wake_pin_drive.sv
// far-side model: external circuitry driving the three wake pins
`timescale 1ns/1ns
`default_nettype none
module wake_pin_drive (
  input  wire logic       mclk,    // system clock
  output logic      [2:0] wake_in  // comparator levels seen by the block
);
  // pins start low, as if pulled down on the board
  initial wake_in = 3'h0;

  // a level change is launched just after an edge and held until the next call
  task automatic drive(input int pin, input logic lvl);
    @(posedge mclk);
    wake_in[pin] <= lvl;
  endtask
endmodule
`default_nettype wire

// ===== tb/wake_measure_ctrl_tb.sv
// self-checking testbench of the wake input measurement block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module wake_measure_ctrl_tb;
  import wake_meas_pkg::*;
  logic       mclk, resetn, wr, rd, sleep_cmd, timer_one_on, timer_two_on;
  logic [7:0] addr, wdata, rdata, got, rnd;
  op_mode_t   op_mode;
  logic [2:0] wake_in, pull_up, pull_down, eu, ed;
  logic       measure_pass_switch, wake_req, sleep_go, restart_req, irq;
  int         miscompares, comparisons, seen, len, shrt;

  wake_pin_drive far_u (.mclk(mclk), .wake_in(wake_in));

  wake_measure_ctrl dut_u (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .op_mode(op_mode), .sleep_cmd(sleep_cmd), .wake_in(wake_in),
    .timer_one_on(timer_one_on), .timer_two_on(timer_two_on),
    .measure_pass_switch(measure_pass_switch), .pull_up(pull_up), .pull_down(pull_down),
    .wake_req(wake_req), .sleep_go(sleep_go), .restart_req(restart_req), .irq(irq)
  );

  // ---------------------------------------------------------------------------
  // clock, hang guard and closing report
  // ---------------------------------------------------------------------------
  always #10 mclk = ~mclk;

  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    conclude();
  end

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // register port cycles and wake watcher
  // ---------------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  // cycle index of the first wake pulse within n cycles, 0 if none
  task automatic watch(input int n, output int first);
    first = 0;
    for (int i = 1; i <= n; i++) begin
      @(posedge mclk);
      #1;
      if (wake_req !== 1'b0 && first == 0) first = i;
    end
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    sleep_cmd = 1'b0;
    timer_one_on = 1'b0;
    timer_two_on = 1'b0;
    op_mode = MODE_NORMAL;
    shrt = int'(FILTER_SHORT_CYC);
    void'($urandom(46));
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    // reset state
    rd_reg(ADDR_CTRL);
    `CHK("ctrl reset", 8'h00, got)
    `CHK("switch reset", 1'b0, measure_pass_switch)
    // pull codes, then with measurement on
    for (int c = 0; c < 4; c++) begin
      wr_reg(ADDR_PULL, {2'h0, 2'(c), 2'(c), 2'(c)});
      eu = (2'(c) == PULL_UP) ? 3'h7 : 3'h0;
      ed = (2'(c) == PULL_DOWN || 2'(c) == PULL_AUTO) ? 3'h7 : 3'h0;
      `CHK("pull up", eu, pull_up)
      `CHK("pull down", ed, pull_down)
      wr_reg(ADDR_CTRL, 8'h01);
      `CHK("pull up gated", eu & 3'h4, pull_up)
      `CHK("pull down gated", ed & 3'h4, pull_down)
      wr_reg(ADDR_CTRL, 8'h00);
    end
    // switch against every mode, enable off and on
    for (int m = 0; m < 2; m++) begin
      wr_reg(ADDR_CTRL, 8'(m));
      for (int k = 0; k < 6; k++) begin
        @(posedge mclk);
        op_mode <= op_mode_t'(k);
        #1;
        `CHK("switch", 1'(m == 1 && k == 1), measure_pass_switch)
      end
    end
    // sleep command table, fault interrupt raised, masked, cleared
    @(posedge mclk);
    op_mode <= MODE_NORMAL;
    for (int t = 0; t < 4; t++) begin
      wr_reg(ADDR_EVENT_MASK, 8'h08);
      wr_reg(ADDR_CTRL, {7'h0, 1'(t < 3)});
      wr_reg(ADDR_WAKE_EN, (t == 1) ? 8'h01 : (t == 2) ? 8'h07 : 8'h03);
      @(posedge mclk);
      sleep_cmd <= 1'b1;
      @(posedge mclk);
      sleep_cmd <= 1'b0;
      #1;
      `CHK("restart", 1'(t < 2), restart_req)
      `CHK("sleep go", 1'(t >= 2), sleep_go)
      `CHK("irq fault", 1'(t < 2), irq)
      wr_reg(ADDR_EVENT_MASK, 8'h00);
      `CHK("irq masked", 1'b0, irq)
      wr_reg(ADDR_EVENT_STAT, 8'h08);
      wr_reg(ADDR_EVENT_MASK, 8'h08);
      `CHK("irq cleared", 1'b0, irq)
    end
    // short filter on the third pin while measurement is on
    @(posedge mclk);
    op_mode <= MODE_SLEEP;
    wr_reg(ADDR_FILTER, 8'h00);
    wr_reg(ADDR_WAKE_EN, 8'h07);
    wr_reg(ADDR_CTRL, 8'h01);
    len = 1 + int'($urandom % 32'(shrt - 2));
    far_u.drive(2, 1'b1);
    watch(len, seen);
    far_u.drive(2, 1'b0);
    `CHK("glitch", 0, seen)
    watch(20, seen);
    `CHK("glitch after", 0, seen)
    far_u.drive(2, 1'b1);
    watch(shrt + 50, seen);
    `CHK("short wake", shrt + 1, seen)
    rd_reg(ADDR_WAKE_STAT);
    `CHK("status pin three", 8'h04, got)
    wr_reg(ADDR_WAKE_STAT, 8'h07);
    // long filter on the first pin, measurement off
    wr_reg(ADDR_CTRL, 8'h00);
    wr_reg(ADDR_FILTER, 8'h01);
    far_u.drive(0, 1'b1);
    watch(int'(FILTER_LONG_CYC) + 50, seen);
    `CHK("long wake", int'(FILTER_LONG_CYC) + 1, seen)
    rd_reg(ADDR_WAKE_STAT);
    `CHK("status pin one", 8'h01, got)
    wr_reg(ADDR_WAKE_STAT, 8'h07);
    // measurement gates pins one and two, settings stay writable
    wr_reg(ADDR_CTRL, 8'h01);
    rnd = 8'($urandom) & 8'h3f;
    wr_reg(ADDR_PULL, rnd);
    rd_reg(ADDR_PULL);
    `CHK("pull readback", rnd, got)
    `CHK("pulls off", 3'h0, (pull_up | pull_down) & 3'h3)
    far_u.drive(0, 1'b0);
    far_u.drive(1, 1'b1);
    watch(int'(FILTER_LONG_CYC) + 50, seen);
    `CHK("gated wake", 0, seen)
    rd_reg(ADDR_WAKE_STAT);
    `CHK("gated status", 8'h00, got)
    far_u.drive(0, 1'b1);
    // cyclic sensing on pin two, each timer, wrong timer first
    wr_reg(ADDR_PULL, 8'h00);
    for (int c = 2; c < 4; c++) begin
      wr_reg(ADDR_FILTER, 8'(c << 2));
      wr_reg(ADDR_CTRL, 8'h00);
      @(posedge mclk);
      timer_one_on <= (c == 3);
      timer_two_on <= (c == 2);
      watch(shrt + 50, seen);
      `CHK("cyclic idle", 0, seen)
      @(posedge mclk);
      timer_one_on <= (c == 2);
      timer_two_on <= (c == 3);
      watch(shrt + 50, seen);
      `CHK("cyclic wake", shrt + 1, seen)
      far_u.drive(1, 1'b0);
      timer_one_on <= 1'b0;
      timer_two_on <= 1'b0;
    end
    // level status in normal mode, gated pin one keeps its last level
    @(posedge mclk);
    op_mode <= MODE_NORMAL;
    rd_reg(ADDR_LEVEL_STAT);
    `CHK("level status", 8'h05, got)
    wr_reg(ADDR_CTRL, 8'h01);
    far_u.drive(0, 1'b0);
    far_u.drive(2, 1'b0);
    watch(shrt + 50, seen);
    `CHK("normal no wake", 0, seen)
    rd_reg(ADDR_LEVEL_STAT);
    `CHK("level frozen", 8'h01, got)
    conclude();
  end
endmodule
`default_nettype wire
